// ### acm_defines.svh
`ifndef ACM_DEFINES_SVH
`define ACM_DEFINES_SVH

// Synchroniser bit positions
`define ACM_I_CS      0
`define ACM_I_SCLK    1
`define ACM_I_DIN     2
`define ACM_I_FS      3
`define ACM_I_WID     4
`define ACM_NSYNC     5
// Synchroniser reset: select and frame-sync at their idle high level
`define ACM_SYNC_RST  5'h09

// Widths and transfer lengths
`define ACM_RES_W     14
`define ACM_WORD_W    16
`define ACM_CMD_W     8
`define ACM_BYTE_LAST 3'h7
`define ACM_WORD_LAST 4'hf

// Conversion time, least, rounded up to cycles of clk
`define ACM_CLK_MHZ   50
`define ACM_CONV_NS   1000
`define ACM_CONV_CYC  ((`ACM_CONV_NS * `ACM_CLK_MHZ + 999) / 1000)
`endif

// ### acm_pkg.sv
package acm_pkg;
    // Power and conversion states, one-hot
    typedef enum logic [2:0] {
        ACM_OFF  = 3'h1,
        ACM_IDLE = 3'h2,
        ACM_CONV = 3'h4
    } acm_state_t;
endpackage : acm_pkg

// ### acm_ctrl.sv
`include "acm_defines.svh"

module acm_ctrl (
    input  wire logic                    clk,             // 50 MHz clock
    input  wire logic                    rst_n,           // Async reset
    input  wire logic                    cs_n,            // Select pin
    input  wire logic                    sclk,            // Serial clock pin
    input  wire logic                    din,             // Serial data pin
    input  wire logic                    frame_sync_receive_in, // Sync pin
    input  wire logic                    transfer_width_select, // Width pin
    input  wire logic                    fs_mode,         // Frame-sync mode
    input  wire logic                    ext_ref_mode,    // External ref
    input  wire logic                    ext_clk_mode,    // External clock
    input  wire logic [`ACM_RES_W-1:0]   conv_data,       // Core result
    output logic                         shutdown,        // Full power-down
    output logic                         ref_power_down,  // Ref+buffer off
    output logic                         conv_busy,       // Converting
    output logic                         eoc_n,           // Conversion done
    output logic                         dout,            // Serial data out
    output logic                         dout_oe,         // Drives dout
    output logic [`ACM_CMD_W-1:0]        cmd_byte,        // Last command
    output logic                         cmd_valid,       // Command pulse
    output logic                         xfer_done,       // Transfer ended
    output logic                         buf_full         // Buffer stalls
);
    import acm_pkg::*;

    // ------------------------------------------------------------------
    // State record
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [`ACM_NSYNC-1:0]              sync1;
        logic [`ACM_NSYNC-1:0]              sync2;
        logic [`ACM_NSYNC-1:0]              prev;
        acm_state_t                         state;
        logic [7:0]                         conv_cnt;
        logic [`ACM_CMD_W-1:0]              cmd_sh;
        logic [2:0]                         cmd_cnt;
        logic [`ACM_CMD_W-1:0]              cmd_byte;
        logic                               cmd_valid;
        logic [1:0][`ACM_WORD_W-1:0]        mem;
        logic                               wr_ptr;
        logic                               rd_ptr;
        logic [1:0]                         count;
        logic [`ACM_WORD_W-1:0]             out_sh;
        logic                               out_loaded;
        logic [3:0]                         bit_cnt;
        logic                               dout;
        logic                               xfer_done;
        logic                               eoc_n;
    } acm_st_t;

    localparam logic [7:0] CONV_LAST = 8'(`ACM_CONV_CYC - 1);

    acm_st_t r;
    acm_st_t next_r;

    // Edge finders read the second synchroniser stage and its delayed copy
    function automatic logic acm_rise(input acm_st_t s, input int i);
        acm_rise = s.sync2[i] & ~s.prev[i];
    endfunction : acm_rise

    function automatic logic acm_fall(input acm_st_t s, input int i);
        acm_fall = ~s.sync2[i] & s.prev[i];
    endfunction : acm_fall

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    logic in_edge;
    logic out_edge;
    logic sel_low;
    logic wide;
    logic start;
    logic push;
    logic pop;
    logic fifo_rdy;
    logic fifo_vld;

    // Whole record computed in one pass
    always_comb begin
        next_r           = r;
        next_r.sync1     = {transfer_width_select, frame_sync_receive_in,
                            din, sclk, cs_n};
        next_r.sync2     = r.sync1;
        next_r.prev      = r.sync2;
        next_r.cmd_valid = 1'b0;
        next_r.xfer_done = 1'b0;
        sel_low          = ~r.sync2[`ACM_I_CS];
        wide             = r.sync2[`ACM_I_WID];
        // Sampling edge swaps with the mode; dout moves on the other edge
        in_edge  = fs_mode ? acm_fall(r, `ACM_I_SCLK)
                           : acm_rise(r, `ACM_I_SCLK);
        out_edge = fs_mode ? acm_rise(r, `ACM_I_SCLK)
                           : acm_fall(r, `ACM_I_SCLK);
        fifo_rdy = (r.count != 2'h2);
        fifo_vld = (r.count != 2'h0);
        // Serial mode starts on a full command; frame-sync mode on a pulse
        start    = fs_mode ? acm_rise(r, `ACM_I_FS)
                           : (r.cmd_valid && r.sync2[`ACM_I_FS]);
        push     = 1'b0;
        pop      = 1'b0;

        unique case (r.state)
            ACM_OFF: begin
                // Only a falling select edge leaves shutdown
                if (acm_fall(r, `ACM_I_CS)) begin
                    next_r.state = ACM_IDLE;
                end
            end
            ACM_IDLE: begin
                // Full buffer holds off the next conversion
                if (start && fifo_rdy) begin
                    next_r.state    = ACM_CONV;
                    next_r.conv_cnt = 8'h00;
                end
            end
            ACM_CONV: begin
                if (r.conv_cnt == CONV_LAST) begin
                    push         = 1'b1;
                    next_r.state = ACM_IDLE;
                end else begin
                    next_r.conv_cnt = r.conv_cnt + 8'h01;
                end
            end
            default: begin
                next_r.state = ACM_OFF;
            end
        endcase
        // Select high wins over everything; staying low keeps running
        if (!sel_low) begin
            next_r.state   = ACM_OFF;
            next_r.cmd_cnt = 3'h0;
            next_r.bit_cnt = 4'h0;
        end

        // Command byte assembly
        if (r.state != ACM_OFF && sel_low && in_edge) begin
            next_r.cmd_sh  = {r.cmd_sh[`ACM_CMD_W-2:0],
                              r.sync2[`ACM_I_DIN]};
            next_r.cmd_cnt = r.cmd_cnt + 3'h1;
            if (r.cmd_cnt == `ACM_BYTE_LAST) begin
                next_r.cmd_byte  = {r.cmd_sh[`ACM_CMD_W-2:0],
                                    r.sync2[`ACM_I_DIN]};
                next_r.cmd_valid = 1'b1;
            end
        end

        // Output shifter drains the buffer; a stalled host fills it
        if (r.out_loaded && r.state != ACM_OFF && sel_low && out_edge) begin
            next_r.dout    = r.out_sh[`ACM_WORD_W-1];
            next_r.out_sh  = {r.out_sh[`ACM_WORD_W-2:0], 1'b0};
            next_r.bit_cnt = r.bit_cnt + 4'h1;
            // A byte frame ends every 8 bits when narrow
            if ((!wide && r.bit_cnt[2:0] == `ACM_BYTE_LAST) ||
                r.bit_cnt == `ACM_WORD_LAST) begin
                next_r.xfer_done = 1'b1;
            end
            if (r.bit_cnt == `ACM_WORD_LAST) begin
                next_r.out_loaded = 1'b0;
            end
        end else if (!r.out_loaded && fifo_vld) begin
            pop               = 1'b1;
            // MSB shows at once, so it stands before the first host sample
            next_r.dout       = r.mem[r.rd_ptr][`ACM_WORD_W-1];
            next_r.out_sh     = {r.mem[r.rd_ptr][`ACM_WORD_W-2:0], 1'b0};
            next_r.out_loaded = 1'b1;
            next_r.bit_cnt    = 4'h0;
        end

        // Two-entry buffer bookkeeping
        if (push) begin
            next_r.mem[r.wr_ptr] = {{(`ACM_WORD_W - `ACM_RES_W){1'b0}},
                                    conv_data};
            next_r.wr_ptr        = ~r.wr_ptr;
        end
        if (pop) begin
            next_r.rd_ptr = ~r.rd_ptr;
        end
        next_r.count = r.count + {1'b0, push} - {1'b0, pop};
        // Shutdown drops pending results; they would be stale on wake
        if (!sel_low) begin
            next_r.count      = 2'h0;
            next_r.out_loaded = 1'b0;
            next_r.wr_ptr     = 1'b0;
            next_r.rd_ptr     = 1'b0;
        end

        // Done flag only means something on the internal clock
        next_r.eoc_n = ext_clk_mode ? 1'b1
                     : !(next_r.count != 2'h0 || next_r.out_loaded);
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // Reset loads constants only; pins are caught after release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r       <= '0;
            r.sync1 <= `ACM_SYNC_RST;
            r.sync2 <= `ACM_SYNC_RST;
            r.prev  <= `ACM_SYNC_RST;
            r.state <= ACM_OFF;
            r.eoc_n <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Reference stays off while shut down or with an external one
    assign shutdown       = (r.state == ACM_OFF);
    assign ref_power_down = ext_ref_mode || shutdown;
    assign conv_busy      = (r.state == ACM_CONV);
    assign eoc_n          = r.eoc_n;
    assign dout           = r.dout;
    assign dout_oe        = !shutdown;
    assign cmd_byte       = r.cmd_byte;
    assign cmd_valid      = r.cmd_valid;
    assign xfer_done      = r.xfer_done;
    assign buf_full       = (r.count == 2'h2);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_sel_high_off;
        r.sync2[`ACM_I_CS] |=> shutdown && !conv_busy;
    endproperty
    a_sel_high_off: assert property (p_sel_high_off)
        else $error("select high but device active");

    property p_wake_on_fall;
        shutdown && r.sync2[`ACM_I_CS] ##1 !r.sync2[`ACM_I_CS]
            |=> !shutdown;
    endproperty
    a_wake_on_fall: assert property (p_wake_on_fall)
        else $error("no wake on select falling edge");

    property p_stay_awake;
        !shutdown && !r.sync2[`ACM_I_CS] |=> !shutdown;
    endproperty
    a_stay_awake: assert property (p_stay_awake)
        else $error("device dropped out with select low");

    property p_fs_start;
        fs_mode && r.state == ACM_IDLE && fifo_rdy && r.sync2[`ACM_I_CS] == 0
            && acm_rise(r, `ACM_I_FS) |=> conv_busy;
    endproperty
    a_fs_start: assert property (p_fs_start)
        else $error("frame sync did not start conversion");

    property p_narrow_frame;
        !wide && r.out_loaded && out_edge && !shutdown && sel_low
            && r.bit_cnt[2:0] == 3'h7 |=> xfer_done;
    endproperty
    a_narrow_frame: assert property (p_narrow_frame)
        else $error("8-bit frame end missing");

    property p_ref_off;
        ext_ref_mode |-> ref_power_down;
    endproperty
    a_ref_off: assert property (p_ref_off)
        else $error("reference on in external mode");

    property p_rise_sample;
        !fs_mode && !shutdown && !r.sync2[`ACM_I_CS]
            && acm_rise(r, `ACM_I_SCLK) |=> r.cmd_sh[0] == $past(r.sync2[2]);
    endproperty
    a_rise_sample: assert property (p_rise_sample)
        else $error("data not sampled on rising clock");

    property p_fall_sample;
        fs_mode && !shutdown && !r.sync2[`ACM_I_CS]
            && acm_fall(r, `ACM_I_SCLK) |=> r.cmd_sh[0] == $past(r.sync2[2]);
    endproperty
    a_fall_sample: assert property (p_fall_sample)
        else $error("data not sampled on falling clock");

    property p_eoc_ready;
        !ext_clk_mode && sel_low && conv_busy && r.conv_cnt == CONV_LAST
            ##1 !ext_clk_mode && sel_low |=> !eoc_n;
    endproperty
    a_eoc_ready: assert property (p_eoc_ready)
        else $error("done not low after conversion");

    property p_eoc_ext;
        $past(ext_clk_mode) |-> eoc_n;
    endproperty
    a_eoc_ext: assert property (p_eoc_ext)
        else $error("done low in external clock mode");
endmodule : acm_ctrl

// ### acm_host_model.sv
module acm_host_model (
    input  wire logic clk,                  // Bench clock
    input  wire logic fs_mode,              // Frame-sync mode
    input  wire logic dout,                 // Serial result
    output logic      cs_n,                 // Select pin
    output logic      sclk,                 // Serial clock
    output logic      din,                  // Serial data
    output logic      frame_sync_receive_in // Sync pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // Host serial port
    // ----------------------------------------------------------------
    logic busy;
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        din = 1'b0;
        frame_sync_receive_in = 1'b1;
        busy = 1'b0;
    end
    // Idle data toggles, so a stale bit never reads as valid
    always @(posedge clk) if (!busy) din <= ~din;
    // Sync input held high outside frame-sync mode
    always @(posedge clk) if (!fs_mode) frame_sync_receive_in <= 1'b1;
    // Select level
    task automatic select(input logic v);
        @(posedge clk) cs_n <= v;
    endtask : select
    // One frame-sync pulse; its rising edge starts a conversion
    task automatic pulse_sync();
        @(posedge clk) frame_sync_receive_in <= 1'b0;
        repeat (3) @(posedge clk);
        frame_sync_receive_in <= 1'b1;
        repeat (3) @(posedge clk);
        frame_sync_receive_in <= 1'b0;
    endtask : pulse_sync
    // Slow bit clock (about 9 cycles a bit), idle low between frames
    task automatic shift(input logic [15:0] tx, input int n,
                         output logic [15:0] rx);
        rx = '0;
        @(posedge clk) busy <= 1'b1;
        @(posedge clk);
        for (int i = n - 1; i >= 0; i--) begin
            din <= tx[i];
            if (fs_mode) begin
                @(negedge clk) rx[i] = dout;
            end
            @(posedge clk) sclk <= 1'b1;
            repeat (4) @(posedge clk);
            if (!fs_mode) begin
                @(negedge clk) rx[i] = dout;
            end
            @(posedge clk) sclk <= 1'b0;
            repeat (3) @(posedge clk);
        end
        busy <= 1'b0;
    endtask : shift
endmodule : acm_host_model

// ### test_adc_host_port_mode_control.sv
`include "acm_defines.svh"

module test_adc_host_port_mode_control;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // Signals and instances
    // ----------------------------------------------------------------
    logic                  clk, rst_n, fs_mode, ext_ref_mode, ext_clk_mode;
    logic                  cs_n, sclk, din, fsr, width_sel, dout, dout_oe;
    logic                  shutdown, ref_power_down, conv_busy, eoc_n;
    logic                  cmd_valid, xfer_done, buf_full;
    logic [`ACM_RES_W-1:0] conv_data;
    logic [7:0]            cmd_byte, cmd;
    logic [15:0]           rx;
    int                    bad_count, compares, xd_cnt, eoc_low, i, xd0, e0;
    int                    cv_cnt, c0;

    acm_host_model host (.clk(clk), .fs_mode(fs_mode), .dout(dout),
        .cs_n(cs_n), .sclk(sclk), .din(din), .frame_sync_receive_in(fsr));

    acm_ctrl dut (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk),
        .din(din), .frame_sync_receive_in(fsr),
        .transfer_width_select(width_sel), .fs_mode(fs_mode),
        .ext_ref_mode(ext_ref_mode), .ext_clk_mode(ext_clk_mode),
        .conv_data(conv_data), .shutdown(shutdown),
        .ref_power_down(ref_power_down), .conv_busy(conv_busy),
        .eoc_n(eoc_n), .dout(dout), .dout_oe(dout_oe),
        .cmd_byte(cmd_byte), .cmd_valid(cmd_valid),
        .xfer_done(xfer_done), .buf_full(buf_full));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Count frame ends and done-low cycles
    always @(posedge clk) begin
        if (xfer_done === 1'b1) xd_cnt <= xd_cnt + 1;
        if (eoc_n !== 1'b1) eoc_low <= eoc_low + 1;
        if (cmd_valid === 1'b1) cv_cnt <= cv_cnt + 1;
    end
    // ----------------------------------------------------------------
    // Checking helpers
    // ----------------------------------------------------------------
    function automatic logic [15:0] word_of(input logic [13:0] r);
        return {2'b00, r};
    endfunction : word_of
    function automatic int frames(input logic w, input int bits);
        return w ? bits / 16 : bits / 8;
    endfunction : frames
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop
    // Hang guard, far beyond the roughly 1500 cycles needed
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        report_and_stop();
    end
    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        {rst_n, fs_mode, ext_ref_mode, ext_clk_mode, width_sel} = '0;
        conv_data = '0;
        {bad_count, compares, xd_cnt, eoc_low, cv_cnt} = '0;
        void'($urandom(94));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (10) @(posedge clk);
        chk(shutdown, 1'b1);
        chk(ref_power_down, 1'b1);
        chk(dout_oe, 1'b0);
        $display("test power-down done");
        for (int w = 0; w < 2; w++) begin
            width_sel <= w[0];
            ext_ref_mode <= 1'($urandom);
            conv_data <= `ACM_RES_W'($urandom);
            cmd = 8'($urandom);
            xd0 = xd_cnt;
            host.select(1'b0);
            repeat (6) @(posedge clk);
            chk(shutdown, 1'b0);
            chk(ref_power_down, ext_ref_mode);
            chk(dout_oe, 1'b1);
            host.shift({8'h00, cmd}, 8, rx);
            repeat (4) @(posedge clk);
            chk(cmd_byte, cmd);
            for (i = 0; i < 20 && conv_busy !== 1'b1; i++) @(posedge clk);
            chk(conv_busy, 1'b1);
            for (i = 0; i < 100 && eoc_n !== 1'b0; i++) @(posedge clk);
            chk(eoc_n, 1'b0);
            host.shift(16'h0000, 16, rx);
            repeat (4) @(posedge clk);
            chk(rx, word_of(conv_data));
            chk(16'(xd_cnt - xd0), 16'(frames(w[0], 16)));
            host.select(1'b1);
            repeat (6) @(posedge clk);
            chk(shutdown, 1'b1);
            chk(conv_busy, 1'b0);
            $display("test serial width %0d done", w);
        end
        ext_clk_mode <= 1'b1;
        host.select(1'b0);
        e0 = eoc_low;
        host.shift({8'h00, cmd}, 8, rx);
        repeat (80) @(posedge clk);
        chk(16'(eoc_low - e0), 16'h0000);
        host.select(1'b1);
        ext_clk_mode <= 1'b0;
        $display("test external clock done");
        // Three results fill shifter and buffer; the fourth is refused
        fs_mode <= 1'b1;
        width_sel <= 1'b1;
        conv_data <= `ACM_RES_W'($urandom);
        host.select(1'b0);
        repeat (6) @(posedge clk);
        for (int k = 0; k < 4; k++) begin
            host.pulse_sync();
            for (i = 0; i < 10 && conv_busy !== 1'b1; i++) @(posedge clk);
            if (k == 0) chk(conv_busy, 1'b1);
            repeat (60) @(posedge clk);
        end
        chk(buf_full, 1'b1);
        c0 = cv_cnt;
        for (int k = 0; k < 3; k++) begin
            cmd = 8'($urandom);
            host.shift({cmd, cmd}, 16, rx);
            chk(rx, word_of(conv_data));
        end
        repeat (6) @(posedge clk);
        chk(cmd_byte, cmd);
        chk(16'(cv_cnt - c0), 16'h0006);
        chk(buf_full, 1'b0);
        chk(eoc_n, 1'b1);
        host.select(1'b1);
        $display("test frame-sync buffer done");
        report_and_stop();
    end
endmodule : test_adc_host_port_mode_control
